// *** fpg_fan_pwm.sv ***
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
// Contract
// - 8-bit counter free-runs and wraps; one period is 256 divided clocks.
// - pulse high while counter below duty value, low after.
// - duty zero gives always low; duty ff gives always high.
// - invert bit flips fan pin, giving 256 minus duty high counts, and none at duty ff.
// - counter clock divides selectable 24 MHz or 200 KHz input tick.
// - divide ratio is prescale field plus one; software keeps 1 to 124.
// - output frequency is input clock over ratio times 256.
// - after reset the 24 MHz source is selected.
// - duty updates are accepted while running.
// - prescale bit 7 selects source: 0 is 24 MHz, 1 is 200 KHz.
module fpg_fan_pwm
  import fpg_pkg::*;
#(
  parameter int cnt_width = fpg_cnt_width
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // input clock ticks, each from its own source
  input wire logic tick_fast_pin,
  input wire logic tick_slow_pin,
  // register port
  input wire fpg_bus_req_type bus_req,
  output logic [7:0] rdata,
  // fan output
  output logic fan_drive_pin
);
  logic [7:0] fan_prescale_reg;
  logic [7:0] fan_duty_reg;
  logic [7:0] ctrl;
  logic [2:0] fast_sync;
  logic [2:0] slow_sync;
  logic [fpg_psc_width-1:0] div_cnt;
  logic [cnt_width-1:0] pwm_cnt;
  logic [7:0] next_rdata;
  logic pwm_out;

  // the counter meets byte-wide paths at the read port and the compare
  function automatic logic [7:0] cnt_to_byte(input logic [cnt_width-1:0] cnt);
    cnt_to_byte = 8'(cnt);
  endfunction

  // stage two already holds the new level and stage three not yet; stage one
  // feeds only stage two, so a metastable first stage never reaches the logic
  function automatic logic sync_rise(input logic [2:0] stages);
    sync_rise = stages[1] & ~stages[2];
  endfunction

  // one write strobe aimed at one register offset
  function automatic logic wr_hit(input fpg_bus_req_type req, input logic [7:0] offset);
    wr_hit = req.wr & (req.addr == offset);
  endfunction

  wire fast_rise = sync_rise(fast_sync);
  wire slow_rise = sync_rise(slow_sync);
  wire enabled = ctrl[fpg_enable_bit];
  wire src_tick = fan_prescale_reg[fpg_clk_sel_bit] ? slow_rise : fast_rise;
  wire div_wrap = (div_cnt == fan_prescale_reg[fpg_psc_width-1:0]);
  wire cnt_step = enabled & src_tick & div_wrap;
  wire wr_psc = wr_hit(bus_req, fpg_prescale_offset);
  wire wr_duty = wr_hit(bus_req, fpg_duty_offset);
  wire wr_ctrl = wr_hit(bus_req, fpg_ctrl_offset);

  // full duty holds high through the wrap: 255 of 256 counts would leave a glitch
  assign pwm_out = (fan_duty_reg == fpg_cnt_full) ? 1'b1 :
                   (cnt_to_byte(pwm_cnt) < fan_duty_reg);

  always_comb begin
    if (bus_req.addr == fpg_prescale_offset) begin
      next_rdata = fan_prescale_reg;
    end else if (bus_req.addr == fpg_duty_offset) begin
      next_rdata = fan_duty_reg;
    end else if (bus_req.addr == fpg_ctrl_offset) begin
      next_rdata = ctrl;
    end else if (bus_req.addr == fpg_status_offset) begin
      next_rdata = cnt_to_byte(pwm_cnt);
    end else begin
      next_rdata = fpg_zero8;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_sync <= 3'h0;
      slow_sync <= 3'h0;
    end else if (clk_en) begin
      fast_sync <= {fast_sync[1:0], tick_fast_pin};
      slow_sync <= {slow_sync[1:0], tick_slow_pin};
    end
  end

  // prescale writes are taken at any time; keeping them out of a running
  // generator is left to software, which the hardware does not police
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_prescale_reg <= fpg_prescale_reset;
      fan_duty_reg <= fpg_duty_reset;
      ctrl <= fpg_ctrl_reset;
    end else if (clk_en) begin
      if (wr_psc) fan_prescale_reg <= bus_req.wdata;
      if (wr_duty) fan_duty_reg <= bus_req.wdata;
      if (wr_ctrl) ctrl <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= fpg_div_zero;
      pwm_cnt <= '0;
    end else if (clk_en) begin
      if (!enabled) begin
        div_cnt <= fpg_div_zero;
        pwm_cnt <= '0;
      end else if (src_tick) begin
        div_cnt <= div_wrap ? fpg_div_zero : div_cnt + 7'h01;
        if (cnt_step) pwm_cnt <= pwm_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= fpg_zero8;
      fan_drive_pin <= 1'b0;
    end else if (clk_en) begin
      rdata <= bus_req.rd ? next_rdata : fpg_zero8;
      fan_drive_pin <= enabled & (pwm_out ^ ctrl[fpg_invert_bit]);
    end
  end

  // divider and counter
  a_cnt_hold_off: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !enabled |=> pwm_cnt == '0 && div_cnt == fpg_div_zero)
    else $error("counter not held while disabled");
  a_cnt_step_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cnt_step |=> pwm_cnt == $past(pwm_cnt) + 1'b1)
    else $error("counter did not step");
  a_cnt_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cnt_step && pwm_cnt == fpg_cnt_full |=> pwm_cnt == '0)
    else $error("counter did not wrap to zero");
  a_div_ratio: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && src_tick && !div_wrap |=> div_cnt == $past(div_cnt) + 7'h01)
    else $error("divider did not advance");
  a_div_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && src_tick && div_wrap |=> div_cnt == fpg_div_zero)
    else $error("divider did not restart");
  a_step_needs_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && src_tick && !div_wrap |=> $stable(pwm_cnt))
    else $error("counter stepped before the divider wrapped");
  a_hold_no_tick: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && !src_tick |=> $stable(div_cnt) && $stable(pwm_cnt))
    else $error("divider or counter moved without a source edge");
  // a missing edge on the chosen source must leave the divider alone
  a_src_select: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && !fan_prescale_reg[fpg_clk_sel_bit] && !fast_rise
    |=> $stable(div_cnt))
    else $error("divider moved without a fast source edge");
  a_slow_select: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && fan_prescale_reg[fpg_clk_sel_bit] && !slow_rise
    |=> $stable(div_cnt))
    else $error("divider moved without a slow source edge");

  // fan pin, one cycle behind the compare
  a_pulse_compare: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && !ctrl[fpg_invert_bit] && fan_duty_reg != fpg_cnt_full
    |=> fan_drive_pin == ($past(pwm_cnt) < $past(fan_duty_reg)))
    else $error("pulse does not follow compare");
  a_duty_zero_low: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && !ctrl[fpg_invert_bit] && fan_duty_reg == fpg_zero8
    |=> !fan_drive_pin)
    else $error("zero duty not low");
  a_duty_full_high: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && !ctrl[fpg_invert_bit] && fan_duty_reg == fpg_cnt_full
    |=> fan_drive_pin)
    else $error("full duty not high");
  a_invert_pin: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && ctrl[fpg_invert_bit] |=> fan_drive_pin == !$past(pwm_out))
    else $error("inverted pin wrong");
  a_invert_zero: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && enabled && ctrl[fpg_invert_bit] && fan_duty_reg == fpg_zero8
    |=> fan_drive_pin)
    else $error("inverted zero duty not high");
  a_pin_off_idle: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !enabled |=> !fan_drive_pin)
    else $error("pin driven while disabled");

  // register port
  sequence s_duty_read;
    clk_en && bus_req.rd && bus_req.addr == fpg_duty_offset;
  endsequence
  sequence s_duty_shown;
    rdata == $past(fan_duty_reg);
  endsequence
  a_duty_update: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && wr_duty |=> fan_duty_reg == $past(bus_req.wdata))
    else $error("duty write lost");
  a_duty_readback: assert property (@(posedge clk) disable iff (!rst_n)
    s_duty_read |=> s_duty_shown)
    else $error("duty read back wrong");
  a_psc_write: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && wr_psc |=> fan_prescale_reg == $past(bus_req.wdata))
    else $error("prescale write lost");
  a_status_count: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.rd && bus_req.addr == fpg_status_offset
    |=> rdata == cnt_to_byte($past(pwm_cnt)))
    else $error("status does not show the counter");

  // reset values: no disable here, so the reset branch itself is watched
  a_reset_source: assert property (@(posedge clk)
    !rst_n |=> !fan_prescale_reg[fpg_clk_sel_bit])
    else $error("slow source selected out of reset");
  a_reset_duty: assert property (@(posedge clk)
    !rst_n |=> fan_duty_reg == fpg_cnt_full)
    else $error("duty not full out of reset");
  a_reset_pin: assert property (@(posedge clk)
    !rst_n |=> !fan_drive_pin)
    else $error("pin driven in reset");
endmodule

// *** fpg_pkg.sv ***
package fpg_pkg;
  localparam int fpg_cnt_width = 8;
  localparam int fpg_psc_width = 7;
  localparam logic [7:0] fpg_prescale_offset = 8'h00;
  localparam logic [7:0] fpg_duty_offset = 8'h01;
  localparam logic [7:0] fpg_ctrl_offset = 8'h02;
  localparam logic [7:0] fpg_status_offset = 8'h03;
  localparam int fpg_clk_sel_bit = 7;
  localparam int fpg_enable_bit = 0;
  localparam int fpg_invert_bit = 1;
  localparam logic [7:0] fpg_prescale_reset = 8'h00;
  localparam logic [7:0] fpg_duty_reset = 8'hff;
  localparam logic [7:0] fpg_ctrl_reset = 8'h00;
  localparam logic [7:0] fpg_cnt_full = 8'hff;
  localparam logic [6:0] fpg_div_zero = 7'h00;
  localparam logic [7:0] fpg_zero8 = 8'h00;
  localparam int fpg_clk_hz = 20000000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fpg_bus_req_type;
endpackage

// *** fpg_fan_model.sv ***
`timescale 1ns/1ns
// fan side: totals the cycles that the drive pin spends high since the last clear
module fpg_fan_model (
  // clock
  input wire logic clk,
  // fan pin and measure control
  input wire logic fan_drive_pin,
  input wire logic clr,
  output logic [15:0] hi
);
  always_ff @(posedge clk) begin
    if (clr) begin
      hi <= 16'h0000;
    end else begin
      hi <= hi + {15'h0000, fan_drive_pin};
    end
  end
endmodule

// *** tb_fpg_fan_pwm.sv ***
`timescale 1ns/1ns
module tb_fpg_fan_pwm;
  import fpg_pkg::*;
  logic clk = 0, rst_n = 0, clr = 0, tf = 0, ts = 0, ce = 1;
  logic [2:0] tc = 3'h0;
  fpg_bus_req_type bus_req = '0;
  logic [7:0] rdata;
  logic fan_drive_pin;
  logic [15:0] hi;
  int errors = 0, checked = 0, cyc = 0;
  fpg_fan_pwm dut (.clk(clk), .rst_n(rst_n), .clk_en(ce), .tick_fast_pin(tf),
    .tick_slow_pin(ts), .bus_req(bus_req), .rdata(rdata), .fan_drive_pin(fan_drive_pin));
  fpg_fan_model fan (.clk(clk), .fan_drive_pin(fan_drive_pin), .clr(clr), .hi(hi));
  initial forever #25 clk = ~clk;
  // ticks far slower than clk so the synchronisers can resolve every edge
  always @(posedge clk) begin
    tc <= tc + 3'h1;
    tf <= tc[1];
    ts <= tc[2];
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus_req <= '0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask
  // settle, then count high cycles over one whole output period
  task automatic meas(input int n, input logic [15:0] exp);
    repeat (n + 20) @(posedge clk);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1 chk(hi, exp);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(fpg_prescale_offset, 8'h00);
    rd(fpg_duty_offset, 8'hff);
    rd(8'h10, 8'h00);
    wr(fpg_duty_offset, 8'h40);
    wr(fpg_ctrl_offset, 8'h01);
    meas(1024, 16'd256);
    wr(fpg_ctrl_offset, 8'h03);
    rd(fpg_ctrl_offset, 8'h03);
    meas(1024, 16'd768);
    wr(fpg_duty_offset, 8'h00);
    meas(1024, 16'd1024);
    wr(fpg_ctrl_offset, 8'h01);
    meas(1024, 16'd0);
    wr(fpg_duty_offset, 8'hff);
    meas(1024, 16'd1024);
    wr(fpg_ctrl_offset, 8'h00);
    meas(64, 16'd0);
    rd(fpg_status_offset, 8'h00);
    wr(fpg_duty_offset, 8'h40);
    wr(fpg_prescale_offset, 8'h01);
    wr(fpg_ctrl_offset, 8'h01);
    meas(2048, 16'd512);
    wr(fpg_ctrl_offset, 8'h00);
    wr(fpg_prescale_offset, 8'h80);
    wr(fpg_ctrl_offset, 8'h01);
    meas(2048, 16'd512);
    // reset in mid-run while running on the slow source
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(fpg_prescale_offset, 8'h00);
    rd(fpg_duty_offset, 8'hff);
    rd(fpg_ctrl_offset, 8'h00);
    // clock enable low: a write must not land
    @(posedge clk) ce <= 1'b0;
    wr(fpg_duty_offset, 8'h11);
    @(posedge clk) ce <= 1'b1;
    rd(fpg_duty_offset, 8'hff);
    stop_test();
  end
endmodule
